// >>> design/stu_defs.svh
// Constants for the software trap and invalid-opcode unit.
// Assumes inclusion by bare name from the design files of this unit.
`ifndef STU_DEFS_SVH
`define STU_DEFS_SVH

// ==========================================================================
// Exception vectors
`define STU_VEC_BREAKPOINT 8'h03
`define STU_VEC_OVERFLOW 8'h04
`define STU_VEC_RANGE 8'h05
`define STU_VEC_INVALID 8'h06

// ==========================================================================
// Opcode bytes
`define STU_OP_BREAKPOINT 8'hCC
`define STU_OP_SOFT_INT 8'hCD
`define STU_OP_TRAP_OVF 8'hCE
`define STU_OP_RANGE_CHECK 8'h62
`define STU_OP_RSV_QUIET_A 8'hD6
`define STU_OP_RSV_QUIET_B 8'hF1
`define STU_OP2_FORCED_UNDEF 8'h0B
`define STU_OP2_RESUME_MGMT 8'hAA
`define STU_SOFT_INT_BP_IMM 8'h03
`define STU_BP_LEN 32'h0000_0001

// ==========================================================================
// Register map
`define STU_ADDR_W 12
`define STU_ADDR_CTRL 12'h000
`define STU_ADDR_FEATURE 12'h004
`define STU_ADDR_EXT_FEATURE 12'h008
`define STU_ADDR_STATUS 12'h00C

// ==========================================================================
// Field positions
`define STU_CTRL_X87_ABSENT 0
`define STU_CTRL_SIMD_SAVE_EN 1
`define STU_CTRL_SIMD_FPEXC_EN 2
`define STU_FEAT_PACKED_INT 23
`define STU_FEAT_SIMD1 25
`define STU_FEAT_SIMD2 26
`define STU_EXT_SIMD3 0
`define STU_EXT_SIMD4 9
`define STU_STAT_VEC_LSB 0
`define STU_STAT_VEC_MSB 7
`define STU_STAT_TRAP 8
`define STU_STAT_SEEN 9
`define STU_STAT_CNT_LSB 16
`define STU_STAT_CNT_MSB 31
`define STU_CNT_INC 16'h0001

`endif

// >>> design/stu_pkg.sv
// Types shared by the software trap and invalid-opcode unit.
// Assumes nothing of its surroundings.
package stu_pkg;

  // ========================================================================
  // Extension class of the retiring instruction
  typedef enum logic [2:0] {
    STU_EXT_NONE = 3'b000,
    STU_EXT_PACKED = 3'b001,
    STU_EXT_SIMD1 = 3'b010,
    STU_EXT_SIMD2 = 3'b011,
    STU_EXT_SIMD3 = 3'b100,
    STU_EXT_SIMD4 = 3'b101
  } stu_ext_t;

  // ========================================================================
  // Whole state of the unit
  typedef struct packed {
    logic [2:0] ctrl;
    logic [2:0] feat;
    logic [1:0] ext;
    logic [31:0] rdata;
    logic exc_valid;
    logic [7:0] vector;
    logic trap;
    logic [15:0] cs;
    logic [31:0] ip;
    logic squash;
    logic retire_ok;
    logic [7:0] last_vec;
    logic last_trap;
    logic seen;
    logic [15:0] count;
  } stu_state_t;

endpackage

// >>> design/stu_range_check.sv
// Signed range comparator for the range-check instruction.
// Assumes bounds and index arrive already fetched, on the same clock.
`timescale 1ns/100ps
module stu_range_check #(
  parameter int W = 32
) (
  // Operands
  input wire logic [W-1:0] index_i,
  input wire logic [W-1:0] lower_i,
  input wire logic [W-1:0] upper_i,
  // Result
  output logic out_of_range_o
);

  // ========================================================================
  // Compare
  // Both bounds are inclusive, so equality with either one is in range.
  always_comb begin
    out_of_range_o = ($signed(index_i) < $signed(lower_i)) ||
                     ($signed(index_i) > $signed(upper_i));
  end

endmodule // stu_range_check

// >>> design/stu_trap_unit.sv
// Software trap and invalid-opcode detection at instruction retirement.
// Assumes the decoder classifies each instruction and that all inputs are
// on CLK_I; registers are reached over a zero-wait APB slave.
`timescale 1ns/100ps
`include "stu_defs.svh"
module stu_trap_unit
  import stu_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Retiring instruction
  input wire logic INSN_RETIRE_I,
  input wire logic INSN_ESC_I,
  input wire logic [7:0] INSN_OPCODE_I,
  input wire logic [7:0] INSN_IMM_I,
  input wire logic [3:0] INSN_LEN_I,
  input wire logic [31:0] INSN_IP_I,
  input wire logic [15:0] INSN_CS_I,
  // Decoder classification
  input wire logic OPCODE_RESERVED_I,
  input wire logic OPERAND_ILLEGAL_I,
  input wire logic [2:0] SIMD_EXT_I,
  input wire logic SIMD_PACKED64_I,
  input wire logic EXEMPT_X87_ABSENT_I,
  input wire logic EXEMPT_STATE_SAVE_I,
  input wire logic SIMD_FP_EXC_I,
  input wire logic LOCK_PREFIX_I,
  input wire logic LOCKABLE_I,
  input wire logic DEST_MEM_I,
  input wire logic PROT_ONLY_I,
  // Processor state
  input wire logic SIGNED_OVERFLOW_FLAG_I,
  input wire logic REAL_OR_V86_I,
  input wire logic SYS_MGMT_MODE_I,
  // Range operands
  input wire logic [31:0] RANGE_INDEX_I,
  input wire logic [31:0] RANGE_LOWER_I,
  input wire logic [31:0] RANGE_UPPER_I,
  // Exception delivery
  output logic EXC_VALID_O,
  output logic [7:0] EXC_VECTOR_O,
  output logic EXC_TRAP_O,
  output logic EXC_ERRCODE_O,
  output logic [15:0] EXC_CS_O,
  output logic [31:0] EXC_IP_O,
  output logic INSN_SQUASH_O,
  output logic RETIRE_DONE_O
);

  // ========================================================================
  // Decode
  stu_state_t s_reg;
  stu_state_t s_next;
  stu_ext_t ext_cls;
  logic out_of_range;
  logic is_bp_byte;
  logic is_soft_bp;
  logic is_ovf_trap;
  logic is_range;
  logic is_forced;
  logic is_resume;
  logic rsv_quiet;
  logic simd_any;
  logic simd_wide;
  logic feat_missing;
  logic ud_any;
  logic apb_wr;
  logic apb_rd_setup;
  logic addr_hit;

  assign ext_cls = stu_ext_t'(SIMD_EXT_I);
  // The breakpoint is recognised from its opcode byte alone, so it may sit
  // over the first byte of any longer instruction.
  assign is_bp_byte = !INSN_ESC_I &&
                      INSN_OPCODE_I == `STU_OP_BREAKPOINT;
  assign is_soft_bp = !INSN_ESC_I && INSN_OPCODE_I == `STU_OP_SOFT_INT &&
                      INSN_IMM_I == `STU_SOFT_INT_BP_IMM;
  assign is_ovf_trap = !INSN_ESC_I && INSN_OPCODE_I == `STU_OP_TRAP_OVF;
  assign is_range = !INSN_ESC_I && INSN_OPCODE_I == `STU_OP_RANGE_CHECK;
  assign is_forced = INSN_ESC_I &&
                     INSN_OPCODE_I == `STU_OP2_FORCED_UNDEF;
  assign is_resume = INSN_ESC_I && INSN_OPCODE_I == `STU_OP2_RESUME_MGMT;
  assign rsv_quiet = !INSN_ESC_I &&
                     (INSN_OPCODE_I == `STU_OP_RSV_QUIET_A ||
                      INSN_OPCODE_I == `STU_OP_RSV_QUIET_B);
  assign simd_any = ext_cls != STU_EXT_NONE;
  assign simd_wide = simd_any && ext_cls != STU_EXT_PACKED;

  always_comb begin
    feat_missing = 1'b0;
    case (ext_cls)
      STU_EXT_PACKED: feat_missing = !s_reg.feat[0];
      STU_EXT_SIMD1: feat_missing = !s_reg.feat[1];
      STU_EXT_SIMD2: feat_missing = !s_reg.feat[2];
      STU_EXT_SIMD3: feat_missing = !s_reg.ext[0];
      STU_EXT_SIMD4: feat_missing = !s_reg.ext[1];
      default: feat_missing = 1'b0;
    endcase
  end

  // Any cause of the invalid-opcode fault; only sampled at retirement.
  assign ud_any =
    (OPCODE_RESERVED_I && !rsv_quiet) ||
    OPERAND_ILLEGAL_I ||
    feat_missing ||
    (simd_any && s_reg.ctrl[`STU_CTRL_X87_ABSENT] &&
     !EXEMPT_X87_ABSENT_I) ||
    (simd_wide && !s_reg.ctrl[`STU_CTRL_SIMD_SAVE_EN] &&
     !EXEMPT_STATE_SAVE_I && !SIMD_PACKED64_I) ||
    (simd_wide && SIMD_FP_EXC_I &&
     !s_reg.ctrl[`STU_CTRL_SIMD_FPEXC_EN]) ||
    is_forced ||
    (LOCK_PREFIX_I && (!LOCKABLE_I || !DEST_MEM_I)) ||
    (PROT_ONLY_I && REAL_OR_V86_I) ||
    (is_resume && !SYS_MGMT_MODE_I);

  stu_range_check #(
    .W(32)
  ) u_range (
    .index_i(RANGE_INDEX_I),
    .lower_i(RANGE_LOWER_I),
    .upper_i(RANGE_UPPER_I),
    .out_of_range_o(out_of_range)
  );

  // ========================================================================
  // APB decode
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign addr_hit = PADDR_I == `STU_ADDR_CTRL ||
                    PADDR_I == `STU_ADDR_FEATURE ||
                    PADDR_I == `STU_ADDR_EXT_FEATURE ||
                    PADDR_I == `STU_ADDR_STATUS;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

  // ========================================================================
  // Next state
  always_comb begin
    logic [31:0] rd;
    rd = '0;
    s_next = s_reg;
    s_next.exc_valid = 1'b0;
    s_next.squash = 1'b0;
    s_next.retire_ok = 1'b0;

    case (PADDR_I)
      `STU_ADDR_CTRL: rd[2:0] = s_reg.ctrl;
      `STU_ADDR_FEATURE: begin
        rd[`STU_FEAT_PACKED_INT] = s_reg.feat[0];
        rd[`STU_FEAT_SIMD1] = s_reg.feat[1];
        rd[`STU_FEAT_SIMD2] = s_reg.feat[2];
      end
      `STU_ADDR_EXT_FEATURE: begin
        rd[`STU_EXT_SIMD3] = s_reg.ext[0];
        rd[`STU_EXT_SIMD4] = s_reg.ext[1];
      end
      `STU_ADDR_STATUS: begin
        rd[`STU_STAT_VEC_MSB:`STU_STAT_VEC_LSB] = s_reg.last_vec;
        rd[`STU_STAT_TRAP] = s_reg.last_trap;
        rd[`STU_STAT_SEEN] = s_reg.seen;
        rd[`STU_STAT_CNT_MSB:`STU_STAT_CNT_LSB] = s_reg.count;
      end
      default: rd = '0;
    endcase
    if (apb_rd_setup) begin
      s_next.rdata = rd;
    end

    if (apb_wr) begin
      case (PADDR_I)
        `STU_ADDR_CTRL: s_next.ctrl = PWDATA_I[2:0];
        `STU_ADDR_FEATURE: s_next.feat = {PWDATA_I[`STU_FEAT_SIMD2],
                                          PWDATA_I[`STU_FEAT_SIMD1],
                                          PWDATA_I[`STU_FEAT_PACKED_INT]};
        `STU_ADDR_EXT_FEATURE: s_next.ext = {PWDATA_I[`STU_EXT_SIMD4],
                                             PWDATA_I[`STU_EXT_SIMD3]};
        default: ;
      endcase
    end

    // Nothing is raised before retirement, so a speculative or prefetched
    // bad instruction that is later discarded leaves no trace.
    if (INSN_RETIRE_I) begin
      s_next.cs = INSN_CS_I;
      s_next.exc_valid = 1'b1;
      s_next.squash = 1'b1;
      if (ud_any) begin
        s_next.vector = `STU_VEC_INVALID;
        s_next.trap = 1'b0;
        s_next.ip = INSN_IP_I;
      end else if (is_range && out_of_range) begin
        s_next.vector = `STU_VEC_RANGE;
        s_next.trap = 1'b0;
        s_next.ip = INSN_IP_I;
      end else if (is_bp_byte) begin
        s_next.vector = `STU_VEC_BREAKPOINT;
        s_next.trap = 1'b1;
        s_next.ip = INSN_IP_I + `STU_BP_LEN;
      end else if (is_soft_bp) begin
        s_next.vector = `STU_VEC_BREAKPOINT;
        s_next.trap = 1'b1;
        s_next.ip = INSN_IP_I + 32'(INSN_LEN_I);
      end else if (is_ovf_trap && SIGNED_OVERFLOW_FLAG_I) begin
        s_next.vector = `STU_VEC_OVERFLOW;
        s_next.trap = 1'b1;
        s_next.ip = INSN_IP_I + 32'(INSN_LEN_I);
      end else begin
        s_next.exc_valid = 1'b0;
        s_next.squash = 1'b0;
        s_next.retire_ok = 1'b1;
      end
      if (s_next.exc_valid) begin
        s_next.last_vec = s_next.vector;
        s_next.last_trap = s_next.trap;
        s_next.seen = 1'b1;
        s_next.count = s_reg.count + `STU_CNT_INC;
      end
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ========================================================================
  // Outputs
  // Every exception squashes the instruction's own writes: faults must not
  // execute, and the two traps have no architectural effect of their own.
  assign INSN_SQUASH_O = s_reg.squash;
  assign PRDATA_O = s_reg.rdata;
  assign EXC_VALID_O = s_reg.exc_valid;
  assign EXC_VECTOR_O = s_reg.vector;
  assign EXC_TRAP_O = s_reg.trap;
  assign EXC_ERRCODE_O = 1'b0;
  assign EXC_CS_O = s_reg.cs;
  assign EXC_IP_O = s_reg.ip;
  assign RETIRE_DONE_O = s_reg.retire_ok;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  a_bp_trap_entry: assert property (
    INSN_RETIRE_I && is_bp_byte && !ud_any |=>
      EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_BREAKPOINT && EXC_TRAP_O &&
      EXC_IP_O == $past(INSN_IP_I) + `STU_BP_LEN)
    else $error("breakpoint trap entry wrong");

  a_soft_int_bp: assert property (
    INSN_RETIRE_I && is_soft_bp && !ud_any |=>
      EXC_VECTOR_O == `STU_VEC_BREAKPOINT &&
      EXC_IP_O == $past(INSN_IP_I) + 32'($past(INSN_LEN_I)))
    else $error("soft interrupt 3 did not breakpoint");

  a_exc_no_write: assert property (
    EXC_VALID_O |-> INSN_SQUASH_O && !RETIRE_DONE_O)
    else $error("excepting instruction allowed to write");

  a_ovf_set_trap: assert property (
    INSN_RETIRE_I && is_ovf_trap && !ud_any && SIGNED_OVERFLOW_FLAG_I |=>
      EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_OVERFLOW && EXC_TRAP_O)
    else $error("overflow trap missing");

  a_ovf_clear_pass: assert property (
    INSN_RETIRE_I && is_ovf_trap && !ud_any && !SIGNED_OVERFLOW_FLAG_I
      |=> !EXC_VALID_O && RETIRE_DONE_O)
    else $error("overflow trap raised with flag clear");

  a_range_fault: assert property (
    INSN_RETIRE_I && is_range && out_of_range && !ud_any |=>
      EXC_VECTOR_O == `STU_VEC_RANGE && !EXC_TRAP_O &&
      EXC_IP_O == $past(INSN_IP_I))
    else $error("range fault entry wrong");

  a_ud_fault: assert property (
    INSN_RETIRE_I && ud_any |=>
      EXC_VECTOR_O == `STU_VEC_INVALID && !EXC_TRAP_O &&
      EXC_IP_O == $past(INSN_IP_I) && EXC_CS_O == $past(INSN_CS_I))
    else $error("invalid opcode fault entry wrong");

  a_x87_absent: assert property (
    INSN_RETIRE_I && simd_any && s_reg.ctrl[`STU_CTRL_X87_ABSENT] &&
      !EXEMPT_X87_ABSENT_I |=> EXC_VECTOR_O == `STU_VEC_INVALID)
    else $error("vector insn ran with x87 absent");

  a_rsv_quiet: assert property (
    INSN_RETIRE_I && rsv_quiet && !OPERAND_ILLEGAL_I && !LOCK_PREFIX_I &&
      !PROT_ONLY_I && !simd_any |=> !EXC_VALID_O)
    else $error("quiet reserved opcode faulted");

  a_retire_only: assert property (
    !INSN_RETIRE_I |=> !EXC_VALID_O && !RETIRE_DONE_O)
    else $error("exception raised without retirement");

  a_no_errcode: assert property (
    EXC_VALID_O |-> !EXC_ERRCODE_O)
    else $error("error code flagged");

  c_bp: cover property (EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_BREAKPOINT);
  c_ovf: cover property (EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_OVERFLOW);
  c_range: cover property (EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_RANGE);
  c_ud: cover property (EXC_VALID_O && EXC_VECTOR_O == `STU_VEC_INVALID);

endmodule // stu_trap_unit

// >>> tb/stu_tb_pkg.sv
// Stimulus record shared by the bench and the core model.
// Assumes the field widths of the unit's retire and classification ports.
package stu_tb_pkg;

  // ========================================================================
  // One instruction as the retire stage presents it
  typedef struct packed {
    logic esc;
    logic [7:0] op;
    logic [7:0] imm;
    logic [3:0] len;
    logic [31:0] ip;
    logic [15:0] cs;
    logic rsv;
    logic ill;
    logic [2:0] ext;
    logic p64;
    logic ex87;
    logic exss;
    logic fpx;
    logic lock;
    logic lockable;
    logic dmem;
    logic prot;
    logic ovf;
    logic rv86;
    logic system_mgmt_mode;
    logic [31:0] idx;
    logic [31:0] lo;
    logic [31:0] up;
  } stu_req_t;

endpackage

// >>> tb/stu_core_model.sv
// Model of the decode and retire pipeline feeding the trap unit.
// Assumes one request at a time from the bench, on the unit's clock.
`timescale 1ns/100ps
module stu_core_model
  import stu_tb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request from the bench
  input wire logic go_i,
  input stu_req_t req_i,
  // Retire stage
  output logic retire_o,
  output stu_req_t req_o
);
  // ========================================================================
  // Retire stage
  // Between retirements the classification lines carry inverted junk, as a
  // speculative decoder would, so only a real retirement may raise a fault.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      retire_o <= 1'b0;
      req_o <= '0;
    end else if (go_i) begin
      retire_o <= 1'b1;
      req_o <= req_i;
    end else begin
      retire_o <= 1'b0;
      req_o <= ~req_o;
    end
  end
endmodule // stu_core_model

// >>> tb/stu_trap_unit_bench.sv
// Self-checking bench for the software trap and invalid-opcode unit.
// Assumes the core model drives retirements and the bench drives APB.
`timescale 1ns/100ps
`include "stu_defs.svh"
module stu_trap_unit_bench
  import stu_tb_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, go = 1'b0, retire;
  logic exc_valid, exc_trap, exc_err, squash, done;
  logic [7:0] exc_vec;
  logic [15:0] exc_cs;
  logic [31:0] exc_ip, rd;
  stu_req_t req = '0;
  stu_req_t q;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  stu_core_model i_core (.clk_i(clk), .reset_i(reset), .go_i(go),
    .req_i(req), .retire_o(retire), .req_o(q));

  stu_trap_unit i_dut (.CLK_I(clk), .RESET_I(reset), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .INSN_RETIRE_I(retire), .INSN_ESC_I(q.esc),
    .INSN_OPCODE_I(q.op), .INSN_IMM_I(q.imm), .INSN_LEN_I(q.len),
    .INSN_IP_I(q.ip), .INSN_CS_I(q.cs), .OPCODE_RESERVED_I(q.rsv),
    .OPERAND_ILLEGAL_I(q.ill), .SIMD_EXT_I(q.ext),
    .SIMD_PACKED64_I(q.p64), .EXEMPT_X87_ABSENT_I(q.ex87),
    .EXEMPT_STATE_SAVE_I(q.exss), .SIMD_FP_EXC_I(q.fpx),
    .LOCK_PREFIX_I(q.lock), .LOCKABLE_I(q.lockable), .DEST_MEM_I(q.dmem),
    .PROT_ONLY_I(q.prot), .SIGNED_OVERFLOW_FLAG_I(q.ovf),
    .REAL_OR_V86_I(q.rv86), .SYS_MGMT_MODE_I(q.system_mgmt_mode),
    .RANGE_INDEX_I(q.idx), .RANGE_LOWER_I(q.lo), .RANGE_UPPER_I(q.up),
    .EXC_VALID_O(exc_valid), .EXC_VECTOR_O(exc_vec), .EXC_TRAP_O(exc_trap),
    .EXC_ERRCODE_O(exc_err), .EXC_CS_O(exc_cs), .EXC_IP_O(exc_ip),
    .INSN_SQUASH_O(squash), .RETIRE_DONE_O(done));

  // ========================================================================
  // Reporting
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs a few hundred cycles; this ceiling only stops hangs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ========================================================================
  // Bus and retire tasks
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] data, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_check(input logic [11:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    check("register", rd, exp);
    check("slverr", 32'(e), 32'h0000_0000);
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [31:0] wd);
    logic e;
    apb(1'b1, a, wd, rd, e);
  endtask

  function automatic stu_req_t plain(input logic [7:0] op);
    stu_req_t r;
    r = '0;
    r.op = op;
    r.len = 4'h3;
    r.ip = 32'h0000_1000;
    r.cs = 16'h0008;
    r.up = 32'h0000_000A;
    return r;
  endfunction

  task automatic do_retire(input stu_req_t r, input logic exc,
    input logic [7:0] vec, input logic trap, input logic [31:0] ip);
    @(posedge clk);
    go <= 1'b1;
    req <= r;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check("valid", 32'(exc_valid), 32'(exc));
    check("squash", 32'(squash), 32'(exc));
    check("done", 32'(done), 32'(!exc));
    check("errcode", 32'(exc_err), 32'h0000_0000);
    if (exc) begin
      check("vector", 32'(exc_vec), 32'(vec));
      check("trap", 32'(exc_trap), 32'(trap));
      check("ip", exc_ip, ip);
      check("cs", 32'(exc_cs), 32'(r.cs));
    end
    @(posedge clk);
    #1;
    check("idle", 32'({exc_valid, done}), 32'h0000_0000);
  endtask

  task automatic fault(input stu_req_t r);
    do_retire(r, 1'b1, `STU_VEC_INVALID, 1'b0, r.ip);
  endtask

  task automatic clean(input stu_req_t r);
    do_retire(r, 1'b0, 8'h00, 1'b0, 32'h0000_0000);
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_registers();
    logic e;
    reg_check(`STU_ADDR_CTRL, 32'h0000_0000);
    reg_check(`STU_ADDR_STATUS, 32'h0000_0000);
    reg_write(`STU_ADDR_FEATURE, 32'hFFFF_FFFF);
    reg_check(`STU_ADDR_FEATURE, 32'h0680_0000);
    reg_write(`STU_ADDR_EXT_FEATURE, 32'hFFFF_FFFF);
    reg_check(`STU_ADDR_EXT_FEATURE, 32'h0000_0201);
    apb(1'b0, 12'h010, 32'h0000_0000, rd, e);
    check("unmapped err", 32'(e), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
  endtask

  task automatic t_traps();
    stu_req_t r;
    r = plain(`STU_OP_BREAKPOINT);
    do_retire(r, 1'b1, `STU_VEC_BREAKPOINT, 1'b1, 32'h0000_1001);
    reg_check(`STU_ADDR_STATUS, 32'h0001_0303);
    r = plain(`STU_OP_SOFT_INT);
    r.imm = `STU_SOFT_INT_BP_IMM;
    do_retire(r, 1'b1, `STU_VEC_BREAKPOINT, 1'b1, 32'h0000_1003);
    r.imm = 8'h04;
    clean(r);
    r = plain(`STU_OP_TRAP_OVF);
    clean(r);
    r.ovf = 1'b1;
    do_retire(r, 1'b1, `STU_VEC_OVERFLOW, 1'b1, 32'h0000_1003);
    r = plain(`STU_OP_RANGE_CHECK);
    r.idx = 32'hFFFF_FFFF;
    do_retire(r, 1'b1, `STU_VEC_RANGE, 1'b0, r.ip);
    r.idx = 32'h0000_000A;
    clean(r);
    r.idx = 32'h0000_000B;
    do_retire(r, 1'b1, `STU_VEC_RANGE, 1'b0, r.ip);
  endtask

  task automatic t_invalid();
    stu_req_t r;
    r = plain(8'h90);
    r.rsv = 1'b1;
    fault(r);
    r.op = `STU_OP_RSV_QUIET_A;
    clean(r);
    r.op = `STU_OP_RSV_QUIET_B;
    clean(r);
    r = plain(8'hC4);
    r.ill = 1'b1;
    fault(r);
    r = plain(`STU_OP2_FORCED_UNDEF);
    r.esc = 1'b1;
    fault(r);
    r = plain(8'h01);
    r.lock = 1'b1;
    fault(r);
    r.lockable = 1'b1;
    fault(r);
    r.dmem = 1'b1;
    clean(r);
    r = plain(8'h00);
    r.esc = 1'b1;
    r.prot = 1'b1;
    clean(r);
    r.rv86 = 1'b1;
    fault(r);
    r = plain(`STU_OP2_RESUME_MGMT);
    r.esc = 1'b1;
    fault(r);
    r.system_mgmt_mode = 1'b1;
    clean(r);
  endtask

  task automatic t_simd();
    stu_req_t r;
    r = plain(8'h58);
    r.esc = 1'b1;
    reg_write(`STU_ADDR_FEATURE, 32'h0000_0000);
    reg_write(`STU_ADDR_EXT_FEATURE, 32'h0000_0000);
    reg_write(`STU_ADDR_CTRL, 32'h0000_0006);
    for (int k = 1; k <= 5; k++) begin
      r.ext = 3'(k);
      fault(r);
    end
    reg_write(`STU_ADDR_FEATURE, 32'h0680_0000);
    reg_write(`STU_ADDR_EXT_FEATURE, 32'h0000_0201);
    for (int k = 1; k <= 5; k++) begin
      r.ext = 3'(k);
      clean(r);
    end
    reg_write(`STU_ADDR_CTRL, 32'h0000_0007);
    r.ext = 3'h2;
    fault(r);
    r.ex87 = 1'b1;
    clean(r);
    r.ex87 = 1'b0;
    reg_write(`STU_ADDR_CTRL, 32'h0000_0004);
    r.ext = 3'h3;
    fault(r);
    r.exss = 1'b1;
    clean(r);
    r.exss = 1'b0;
    r.ext = 3'h2;
    r.p64 = 1'b1;
    clean(r);
    r.p64 = 1'b0;
    reg_write(`STU_ADDR_CTRL, 32'h0000_0002);
    r.ext = 3'h4;
    r.fpx = 1'b1;
    fault(r);
    reg_write(`STU_ADDR_CTRL, 32'h0000_0006);
    clean(r);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_registers();
    t_traps();
    t_invalid();
    t_simd();
    complete_run();
  end
endmodule // stu_trap_unit_bench
